/* logic/ppl_fifo.sv */
// flip-flop fifo with valid and ready on both sides
// assumes one clock; push and pop may happen in the same cycle
`timescale 1ns/1ns
module ppl_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // occupancy
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // refuse depths the pointer wrap cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];
    assign level = cnt_q;

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    // occupancy count
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

/* logic/ppl_pkg.sv */
// shared constants and carrier types for the palette pixel input latch
// assumes a single pixel clock that also clocks the register bus
package ppl_pkg;

    // datapath widths and depths
    localparam int INDEX_W = 8;
    localparam int OVL_W = 4;
    localparam int CHAN_W = 8;
    localparam int PAL_DEPTH = 256;
    localparam int OVL_DEPTH = 16;
    localparam int FIFO_DEPTH = 32;

    // register byte offsets
    localparam logic [7:0] PAL_ADDR_OFS = 8'h00;
    localparam logic [7:0] PAL_DATA_OFS = 8'h04;
    localparam logic [7:0] OVL_ADDR_OFS = 8'h08;
    localparam logic [7:0] OVL_DATA_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    // status field positions
    localparam int ST_PEDESTAL_BIT = 0;
    localparam int ST_FULL_BIT = 1;
    localparam int ST_EMPTY_BIT = 2;
    localparam int ST_LEVEL_LSB = 8;

    // reset values
    localparam logic [23:0] COLOR_RST = 24'h000000;
    localparam logic [7:0] ADDR_RST = 8'h00;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one captured pixel with its timing controls
    typedef struct packed {
        logic [INDEX_W-1:0] index;
        logic [OVL_W-1:0] overlay;
        logic sync_n;
        logic blank_n;
    } ppl_pix_t;

    // one palette or overlay color
    typedef struct packed {
        logic [CHAN_W-1:0] red;
        logic [CHAN_W-1:0] green;
        logic [CHAN_W-1:0] blue;
    } ppl_color_t;

endpackage

/* logic/ppl_strap_sync.sv */
// three-stage filter for a slow level arriving on a pin
// assumes the level is quasi static; a change counts once stages two and three agree
`timescale 1ns/1ns
module ppl_strap_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin level and filtered level
    input wire logic pin,
    output logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    // synchroniser chain, first stage read only by the second
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a new level only when the last two stages agree
    always_ff @(posedge clk) begin
        if (rst) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

    assign level = level_q;
endmodule

/* logic/ppl_top.sv */
// pixel input stage of a palette video converter with an axi4-lite register port
// assumes MCLK is the pixel clock and the controller drives pixels on that clock
`timescale 1ns/1ns

// Functional notes
// [R1] blank low at capture forces all three color outputs to blanking level
// [R2] while blank is low, pixel index and overlay select are ignored
// [R3] pedestal pin low gives 0 IRE pedestal, high gives 7.5 IRE
// [R4] sync low at capture switches off the 40 IRE source on all outputs
// [R5] sync acts alone and never overrides blank, index or overlay
// [R6] controller asserts sync only inside the blanking interval
// [R7] index, overlay, sync and blank are captured together every rising edge; the capture register holds them while PIX_READY is low
// [R8] eight-bit index, bit 0 least significant, picks one of 256 palette entries
// [R9] overlay select, bit 0 least significant, picks source; overlay ignores index
// [R10] overlay zero picks the main palette, nonzero picks one of fifteen overlays
module ppl_top #(
    parameter int FIFO_DEPTH = ppl_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // pixel stream from the display controller
    input wire logic PIX_VALID,
    output logic PIX_READY,
    input wire logic [ppl_pkg::INDEX_W-1:0] PIXEL_INDEX,
    input wire logic [ppl_pkg::OVL_W-1:0] OVERLAY_SELECT,
    input wire logic SYNC_N,
    input wire logic BLANK_N,
    // pedestal strap pin
    input wire logic PEDESTAL_SEL,
    // color current output codes
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [ppl_pkg::CHAN_W-1:0] COLOR_CURRENT_R,
    output logic [ppl_pkg::CHAN_W-1:0] COLOR_CURRENT_G,
    output logic [ppl_pkg::CHAN_W-1:0] COLOR_CURRENT_B,
    output logic OUT_BLANK,
    output logic OUT_SYNC_SOURCE_ON,
    output logic OUT_PEDESTAL_75,
    // axi4-lite write address and data
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    localparam int PW = $bits(ppl_pkg::ppl_pix_t);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    if (FIFO_DEPTH < 2) begin : g_bad_fifo
        $error("fifo depth too small");
    end

    // address decode shared by write and read paths
    function automatic logic [2:0] reg_sel(input logic [7:0] addr);
        unique case (addr)
            ppl_pkg::PAL_ADDR_OFS: reg_sel = 3'h1;
            ppl_pkg::PAL_DATA_OFS: reg_sel = 3'h2;
            ppl_pkg::OVL_ADDR_OFS: reg_sel = 3'h3;
            ppl_pkg::OVL_DATA_OFS: reg_sel = 3'h4;
            ppl_pkg::STATUS_OFS: reg_sel = 3'h5;
            default: reg_sel = 3'h0;
        endcase
    endfunction

    // merge a 24-bit color under byte strobes
    function automatic ppl_pkg::ppl_color_t strobe_merge(
        input ppl_pkg::ppl_color_t old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [23:0] v;
        v = old;
        for (int i = 0; i < 3; i++) begin
            if (strb[i]) begin
                v[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        strobe_merge = v;
    endfunction

    // storage
    ppl_pkg::ppl_color_t pal_q [ppl_pkg::PAL_DEPTH];
    ppl_pkg::ppl_color_t ovl_q [ppl_pkg::OVL_DEPTH];
    logic [7:0] pal_addr_q;
    logic [3:0] ovl_addr_q;

    // capture and pipeline
    ppl_pkg::ppl_pix_t cap_q;
    logic cap_valid_q;
    ppl_pkg::ppl_pix_t fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [LW-1:0] fifo_level;
    logic pedestal_lvl;
    logic out_valid_q;
    ppl_pkg::ppl_color_t color_q;
    logic blank_q;
    logic sync_on_q;
    logic ped_q;
    logic out_stall;
    logic pop;

    // bus state
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_fire;
    logic [2:0] wsel;
    logic [2:0] rsel;
    logic [31:0] rd_d;

    // strap filter for the pedestal select pin
    ppl_strap_sync u_ped (
        .clk(MCLK),
        .rst(RESET),
        .pin(PEDESTAL_SEL),
        .level(pedestal_lvl)
    );

    // capture all four pixel-side inputs on each rising edge where the capture register can move
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            cap_q <= '{index: '0, overlay: '0, sync_n: 1'b1, blank_n: 1'b0};
            cap_valid_q <= 1'b0;
        end else if (!cap_valid_q || fifo_in_ready) begin
            cap_q.index <= PIXEL_INDEX; // [R7] [R8]
            cap_q.overlay <= OVERLAY_SELECT; // [R7] [R9]
            cap_q.sync_n <= SYNC_N; // [R7]
            cap_q.blank_n <= BLANK_N; // [R7]
            cap_valid_q <= PIX_VALID;
        end
    end

    // controller sees back-pressure when the capture register cannot move
    assign PIX_READY = !cap_valid_q || fifo_in_ready;

    ppl_fifo #(
        .WIDTH(PW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst(RESET),
        .in_valid(cap_valid_q),
        .in_ready(fifo_in_ready),
        .in_data(cap_q),
        .out_valid(fifo_out_valid),
        .out_ready(!out_stall),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    assign out_stall = out_valid_q && !OUT_READY;
    assign pop = fifo_out_valid && !out_stall;

    // color lookup and output stage
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            out_valid_q <= 1'b0;
            color_q <= ppl_pkg::COLOR_RST;
            blank_q <= 1'b1;
            sync_on_q <= 1'b1;
            ped_q <= 1'b0;
        end else if (!out_stall) begin
            out_valid_q <= fifo_out_valid;
            if (pop) begin
                // sync only gates its own source, color path unaffected
                sync_on_q <= fifo_out.sync_n; // [R4] [R5]
                blank_q <= !fifo_out.blank_n; // [R1]
                ped_q <= pedestal_lvl && fifo_out.blank_n; // [R3]
                if (!fifo_out.blank_n) begin
                    color_q <= ppl_pkg::COLOR_RST; // [R1] [R2]
                end else if (fifo_out.overlay != '0) begin
                    color_q <= ovl_q[fifo_out.overlay]; // [R9] [R10]
                end else begin
                    color_q <= pal_q[fifo_out.index]; // [R8] [R10]
                end
            end
        end
    end

    assign OUT_VALID = out_valid_q;
    assign COLOR_CURRENT_R = color_q.red;
    assign COLOR_CURRENT_G = color_q.green;
    assign COLOR_CURRENT_B = color_q.blue;
    assign OUT_BLANK = blank_q;
    assign OUT_SYNC_SOURCE_ON = sync_on_q;
    assign OUT_PEDESTAL_75 = ped_q;

    // write address and data are taken independently
    assign S_AXI_AWREADY = !aw_held_q;
    assign S_AXI_WREADY = !w_held_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wsel = reg_sel(awaddr_q);

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
        end else if (S_AXI_AWVALID && !aw_held_q) begin
            aw_held_q <= 1'b1;
            awaddr_q <= {S_AXI_AWADDR[7:2], 2'b00};
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            w_held_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (S_AXI_WVALID && !w_held_q) begin
            w_held_q <= 1'b1;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // write response after both halves have met
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            bvalid_q <= 1'b0;
            bresp_q <= ppl_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wsel == 3'h0) ? ppl_pkg::RESP_SLVERR : ppl_pkg::RESP_OKAY;
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;

    // palette address, advances by one in each cycle with a palette data write or read, unless an address write loads it then
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            pal_addr_q <= ppl_pkg::ADDR_RST;
        end else if (wr_fire && wsel == 3'h1 && wstrb_q[0]) begin
            pal_addr_q <= wdata_q[7:0];
        end else if ((wr_fire && wsel == 3'h2)
                     || (S_AXI_ARVALID && S_AXI_ARREADY && rsel == 3'h2)) begin
            pal_addr_q <= pal_addr_q + 8'h01;
        end
    end

    // overlay address
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ovl_addr_q <= '0;
        end else if (wr_fire && wsel == 3'h3 && wstrb_q[0]) begin
            ovl_addr_q <= wdata_q[3:0];
        end
    end

    // palette and overlay storage writes
    always_ff @(posedge MCLK) begin
        if (wr_fire && wsel == 3'h2) begin
            pal_q[pal_addr_q] <= strobe_merge(pal_q[pal_addr_q], wdata_q, wstrb_q);
        end
        if (wr_fire && wsel == 3'h4) begin
            ovl_q[ovl_addr_q] <= strobe_merge(ovl_q[ovl_addr_q], wdata_q, wstrb_q);
        end
    end

    // read path, one read at a time
    assign S_AXI_ARREADY = !rvalid_q;
    assign rsel = reg_sel({S_AXI_ARADDR[7:2], 2'b00});

    always_comb begin
        rd_d = '0;
        unique case (rsel)
            3'h1: rd_d[7:0] = pal_addr_q;
            3'h2: rd_d[23:0] = pal_q[pal_addr_q];
            3'h3: rd_d[3:0] = ovl_addr_q;
            3'h4: rd_d[23:0] = ovl_q[ovl_addr_q];
            3'h5: begin
                rd_d[ppl_pkg::ST_PEDESTAL_BIT] = pedestal_lvl;
                rd_d[ppl_pkg::ST_FULL_BIT] = !fifo_in_ready;
                rd_d[ppl_pkg::ST_EMPTY_BIT] = !fifo_out_valid;
                rd_d[ppl_pkg::ST_LEVEL_LSB +: LW] = fifo_level;
            end
            default: rd_d = '0;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= ppl_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_d;
            rresp_q <= (rsel == 3'h0) ? ppl_pkg::RESP_SLVERR : ppl_pkg::RESP_OKAY;
        end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
endmodule

/* verification/ppl_ctrl_model.sv */
// behavioural display controller that feeds the pixel stream
// assumes send and idle are called just after a rising clock edge
`timescale 1ns/1ns
module ppl_ctrl_model (
    // clock
    input wire logic clk,
    // pixel link
    input wire logic pix_ready,
    output logic pix_valid,
    output ppl_pkg::ppl_pix_t pix
);
    // nothing offered before the first send
    initial begin
        pix_valid = 1'b0;
        pix = '1;
    end
    // present one word on the edge, hold it until taken
    task automatic send(input ppl_pkg::ppl_pix_t p);
        logic hs;
        p.sync_n = p.sync_n | p.blank_n;
        pix_valid <= 1'b1;
        pix <= p;
        do begin
            @(negedge clk);
            hs = pix_ready;
            @(posedge clk);
        end while (!hs);
    endtask
    // released lines show the inverse of the last word
    task automatic idle;
        pix_valid <= 1'b0;
        pix <= ~pix;
    endtask
endmodule

/* verification/ppl_top_props.sv */
// port-level assertions for the palette pixel input latch
// assumes one clock MCLK and synchronous active-high RESET
`timescale 1ns/1ns
module ppl_top_props (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // pixel side
    input wire logic PIX_READY,
    input wire logic PEDESTAL_SEL,
    // output side
    input wire logic OUT_VALID,
    input wire logic OUT_READY,
    input wire logic [ppl_pkg::CHAN_W-1:0] COLOR_CURRENT_R,
    input wire logic [ppl_pkg::CHAN_W-1:0] COLOR_CURRENT_G,
    input wire logic [ppl_pkg::CHAN_W-1:0] COLOR_CURRENT_B,
    input wire logic OUT_BLANK,
    input wire logic OUT_SYNC_SOURCE_ON,
    input wire logic OUT_PEDESTAL_75,
    // register bus handshakes
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    logic [3:0] settle_q;
    // cycles with a steady strap and a moving output
    always_ff @(posedge MCLK) begin
        if (RESET || $changed(PEDESTAL_SEL)
            || (OUT_VALID && !OUT_READY && settle_q != 4'hA)) begin
            settle_q <= 4'h0;
        end else if (settle_q != 4'hA) begin
            settle_q <= settle_q + 4'h1;
        end
    end
    property p_blank_black;
        OUT_VALID && OUT_BLANK |-> {COLOR_CURRENT_R, COLOR_CURRENT_G, COLOR_CURRENT_B} == 24'h0;
    endproperty
    a_blank_black: assert property (p_blank_black) else $error("blank with color");
    property p_blank_no_ped;
        OUT_PEDESTAL_75 |-> !OUT_BLANK;
    endproperty
    a_blank_no_ped: assert property (p_blank_no_ped) else $error("pedestal in blanking");
    property p_ped_follow;
        (settle_q == 4'hA) && OUT_VALID && !OUT_BLANK |-> OUT_PEDESTAL_75 == PEDESTAL_SEL;
    endproperty
    a_ped_follow: assert property (p_ped_follow) else $error("pedestal not strap");
    property p_out_hold;
        OUT_VALID && !OUT_READY |=> OUT_VALID && $stable({COLOR_CURRENT_R, COLOR_CURRENT_G,
            COLOR_CURRENT_B, OUT_BLANK, OUT_SYNC_SOURCE_ON, OUT_PEDESTAL_75});
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output word moved");
    property p_after_reset;
        $fell(RESET) |-> !OUT_VALID && OUT_BLANK && OUT_SYNC_SOURCE_ON && PIX_READY;
    endproperty
    a_after_reset: assert property (p_after_reset) else $error("bad state after reset");
    property p_wr_resp;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    property p_b_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_resp;
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read response late");
    property p_r_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data moved");
endmodule

bind ppl_top ppl_top_props u_ppl_top_props (.MCLK(MCLK), .RESET(RESET),
    .PIX_READY(PIX_READY), .PEDESTAL_SEL(PEDESTAL_SEL), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .COLOR_CURRENT_R(COLOR_CURRENT_R),
    .COLOR_CURRENT_G(COLOR_CURRENT_G), .COLOR_CURRENT_B(COLOR_CURRENT_B),
    .OUT_BLANK(OUT_BLANK), .OUT_SYNC_SOURCE_ON(OUT_SYNC_SOURCE_ON),
    .OUT_PEDESTAL_75(OUT_PEDESTAL_75), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

/* verification/tb_ppl_top.sv */
// self-checking bench for the palette pixel input latch
// assumes the controller model and the port checker are compiled before it
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_ppl_top;
    logic MCLK = 1'b0;
    logic RESET = 1'b1;
    logic PEDESTAL_SEL = 1'b0;
    logic OUT_READY = 1'b0;
    logic PIX_VALID, PIX_READY, OUT_VALID, OUT_BLANK, OUT_SYNC_SOURCE_ON, OUT_PEDESTAL_75;
    logic [7:0] COLOR_CURRENT_R, COLOR_CURRENT_G, COLOR_CURRENT_B;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    ppl_pkg::ppl_pix_t pix;
    ppl_pkg::ppl_color_t pal [256];
    ppl_pkg::ppl_color_t ovl [16];
    logic [26:0] exp_q [$];
    logic [26:0] mon_ex;
    int errors = 0;
    int total_checks = 0;
    int rdy_mode = 1;
    // 25 MHz clock
    initial forever #20 MCLK = ~MCLK;
    ppl_top #(.FIFO_DEPTH(4)) u_ppl_top (.MCLK(MCLK), .RESET(RESET),
        .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .PIXEL_INDEX(pix.index),
        .OVERLAY_SELECT(pix.overlay), .SYNC_N(pix.sync_n), .BLANK_N(pix.blank_n),
        .PEDESTAL_SEL(PEDESTAL_SEL), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
        .COLOR_CURRENT_R(COLOR_CURRENT_R), .COLOR_CURRENT_G(COLOR_CURRENT_G),
        .COLOR_CURRENT_B(COLOR_CURRENT_B), .OUT_BLANK(OUT_BLANK),
        .OUT_SYNC_SOURCE_ON(OUT_SYNC_SOURCE_ON), .OUT_PEDESTAL_75(OUT_PEDESTAL_75),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1));
    ppl_ctrl_model u_ppl_ctrl_model (.clk(MCLK), .pix_ready(PIX_READY),
        .pix_valid(PIX_VALID), .pix(pix));
    // sink readiness: fixed or random stalls
    always @(posedge MCLK) begin
        OUT_READY <= (rdy_mode == 2) ? 1'($urandom % 2) : rdy_mode[0];
    end
    // compare each taken output word with the oldest note
    always @(posedge MCLK) begin
        if (!RESET && OUT_VALID && OUT_READY) begin
            mon_ex = (exp_q.size() != 0) ? exp_q.pop_front() : 27'h0;
            `CHK("pixel out", mon_ex, {COLOR_CURRENT_R, COLOR_CURRENT_G, COLOR_CURRENT_B,
                OUT_BLANK, OUT_SYNC_SOURCE_ON,
                OUT_PEDESTAL_75})
        end
    end
    // expected output word for one pixel
    function automatic logic [26:0] expect_px(ppl_pkg::ppl_pix_t p);
        ppl_pkg::ppl_color_t c;
        c = (p.overlay == 4'h0) ? pal[p.index] : ovl[p.overlay];
        if (!p.blank_n) c = 24'h000000;
        return {c, !p.blank_n, p.sync_n, PEDESTAL_SEL & p.blank_n};
    endfunction
    // one write, both halves offered together; bready is always high
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        logic ah, wh, bh;
        logic [1:0] r;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge MCLK);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid;
            r = bresp;
            @(posedge MCLK);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end while (!bh);
        `CHK("write resp", er, r)
    endtask
    // one read; rready is always high
    task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
        logic ah, rh;
        logic [1:0] r;
        logic [31:0] d;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge MCLK);
            ah = arvalid & arready;
            rh = rvalid;
            r = rresp;
            d = rdata;
            @(posedge MCLK);
            if (ah) arvalid <= 1'b0;
        end while (!rh);
        `CHK("read resp", er, r)
        `CHK("read data", ed, d)
    endtask
    // random pixels, overlay select counting up on every third pixel, sync only inside blanking
    task automatic stream(input int n);
        ppl_pkg::ppl_pix_t p;
        for (int i = 0; i < n; i++) begin
            p.index = 8'($urandom);
            p.overlay = (i % 3 == 0) ? 4'(i / 3) : 4'h0;
            p.blank_n = ($urandom % 4) != 0;
            p.sync_n = p.blank_n | 1'($urandom);
            exp_q.push_back(expect_px(p));
            u_ppl_ctrl_model.send(p);
        end
        u_ppl_ctrl_model.idle();
    endtask
    // wait until every noted word came out
    task automatic drain;
        for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge MCLK);
        `CHK("words left", 0, exp_q.size())
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (40000) @(posedge MCLK);
        errors++;
        $display("Error watchdog expected done seen hang");
        wrap_up();
    end
    // main sequence
    initial begin
        void'($urandom(36148));
        repeat (12) @(posedge MCLK);
        RESET <= 1'b0;
        repeat (6) @(posedge MCLK);
        wr(ppl_pkg::PAL_ADDR_OFS, 32'h0, 4'hF, ppl_pkg::RESP_OKAY);
        for (int i = 0; i < 256; i++) begin
            pal[i] = 24'($urandom);
            wr(ppl_pkg::PAL_DATA_OFS, {8'h00, pal[i]}, 4'hF, ppl_pkg::RESP_OKAY);
        end
        for (int i = 0; i < 16; i++) begin
            ovl[i] = 24'($urandom);
            wr(ppl_pkg::OVL_ADDR_OFS, 32'(i), 4'hF, ppl_pkg::RESP_OKAY);
            wr(ppl_pkg::OVL_DATA_OFS, {8'h00, ovl[i]}, 4'hF, ppl_pkg::RESP_OKAY);
        end
        wr(ppl_pkg::PAL_ADDR_OFS, 32'h5, 4'hF, ppl_pkg::RESP_OKAY);
        rd(ppl_pkg::PAL_DATA_OFS, ppl_pkg::RESP_OKAY, {8'h00, pal[5]});
        rd(ppl_pkg::PAL_DATA_OFS, ppl_pkg::RESP_OKAY, {8'h00, pal[6]});
        // red byte alone through its strobe
        pal[3].red = 8'hAB;
        wr(ppl_pkg::PAL_ADDR_OFS, 32'h3, 4'hF, ppl_pkg::RESP_OKAY);
        wr(ppl_pkg::PAL_DATA_OFS, 32'h00AB5A5A, 4'h4, ppl_pkg::RESP_OKAY);
        wr(ppl_pkg::PAL_ADDR_OFS, 32'h3, 4'hF, ppl_pkg::RESP_OKAY);
        rd(ppl_pkg::PAL_DATA_OFS, ppl_pkg::RESP_OKAY, {8'h00, pal[3]});
        // unmapped offset
        wr(8'h14, 32'hFFFFFFFF, 4'hF, ppl_pkg::RESP_SLVERR);
        rd(8'h14, ppl_pkg::RESP_SLVERR, 32'h0);
        rd(ppl_pkg::STATUS_OFS, ppl_pkg::RESP_OKAY, 32'h00000004);
        rdy_mode <= 2;
        stream(64);
        drain();
        PEDESTAL_SEL <= 1'b1;
        repeat (10) @(posedge MCLK);
        rd(ppl_pkg::STATUS_OFS, ppl_pkg::RESP_OKAY, 32'h00000005);
        stream(48);
        drain();
        // sink stalls until the input side refuses
        rdy_mode <= 0;
        fork
            stream(12);
            begin
                repeat (30) @(posedge MCLK);
                @(negedge MCLK);
                `CHK("pixel ready", 1'b0, PIX_READY)
                @(posedge MCLK);
                rd(ppl_pkg::STATUS_OFS, ppl_pkg::RESP_OKAY, 32'h00000403);
                rdy_mode <= 2;
            end
        join
        drain();
        rd(ppl_pkg::STATUS_OFS, ppl_pkg::RESP_OKAY, 32'h00000005);
        wrap_up();
    end
endmodule
